// File: hw/ccr_pkg.sv
// Purpose: Constants and types for the clock generator configuration slave
// Assumes: Register offsets are byte positions on the two-wire bus
// Notes: Offset 0x05 keeps only its three low bits in this block
package ccr_pkg;

  localparam int CCR_NUM_REGS = 6;

  localparam logic [7:0] OFS_GENERAL = 8'h00;
  localparam logic [7:0] OFS_VARIANT = 8'h01;
  localparam logic [7:0] OFS_CAP_TRIM = 8'h02;
  localparam logic [7:0] OFS_REF_DIV = 8'h03;
  localparam logic [7:0] OFS_FB_LOW = 8'h04;
  localparam logic [7:0] OFS_FB_HIGH = 8'h05;

  localparam int GC_OTP_PROGRAMMED = 7;
  localparam int GC_ADDR_SEL_LSB = 5;
  localparam int GC_SPREAD = 4;
  localparam int GC_DIVA_SRC = 3;
  localparam int GC_PLLC_REF = 2;
  localparam int GC_CLKIN_EN = 1;
  localparam int GC_OTP_LOCK = 0;
  localparam int RD_BYPASS_ONE = 7;
  localparam int RD_BYPASS_TWO = 6;
  localparam int RD_DIV_MSB = 5;
  localparam int FBH_MSB = 2;

  localparam logic [7:0] RST_GENERAL = 8'h00;
  localparam logic [7:0] RST_VARIANT = 8'h00;
  localparam logic [7:0] RST_CAP_TRIM = 8'h11;
  localparam logic [7:0] RST_REF_DIV = 8'h19;
  localparam logic [7:0] RST_FB_LOW = 8'hE0;
  localparam logic [7:0] RST_FB_HIGH = 8'h01;
  localparam logic [7:0] MASK_FB_HIGH = 8'h07;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  localparam logic [7:0] CCR_RESET [CCR_NUM_REGS] = '{RST_GENERAL,
    RST_VARIANT, RST_CAP_TRIM, RST_REF_DIV, RST_FB_LOW, RST_FB_HIGH};
  localparam logic [7:0] CCR_MASK [CCR_NUM_REGS] = '{MASK_FULL, MASK_FULL,
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FB_HIGH};

  // Upper five bits of the seven-bit slave address; select adds 0..3
  localparam logic [4:0] SLAVE_ADDR_HIGH = 5'h1A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_OFFS, ST_WR, ST_RD, ST_HOLD
  } ccr_state_t;

endpackage

// File: hw/ccr_slave.sv
// Purpose: Two-wire slave holding the first configuration bytes
// Assumes: SCL and SDA_IN are synchronous to SYS_CLK and slow against it
// Notes: Writes are staged and land together at STOP
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Answers at one of four slave addresses, D0, D2, D4 or D6.
// - Transfers are byte blocks of one or more data bytes after addressing.
// - Slave address byte then offset byte; offset is the first register used.
// - Pointer steps up after every written byte and every read byte the master acknowledges; bits go most significant first.
// - Master may stop after any whole byte without error.
// - Written bytes are staged and all committed together at STOP.
// - Offset 0x00 bits 6:5 pick the slave address.
// - Offset 0x00 bit 7 marks programmed memory; bit 0 locks it.
// - Offset 0x00 bit 4 enables spread on the first PLL, reset 0.
// - Offset 0x00 bits 3:1: divider source, third PLL reference, clock input.
// - Offset 0x01 is an eight-bit variant code, reset zero.
// - Offset 0x02 is the eight-bit crystal capacitance trim.
// - Offset 0x03 bits 5:0 are the third PLL reference divider, reset 25.
// - Offset 0x03 bits 7 and 6 bypass the divide-by-one and -two paths.
// - Offset 0x04 is the low byte of the third PLL feedback divider.
// - Offset 0x05 bits 2:0 are feedback divider bits 10:8.
module ccr_slave
  import ccr_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic OTP_PROGRAMMED,
  output logic [1:0] SLAVE_ADDR_SELECT,
  output logic PLL_A_SPREAD_ENABLE,
  output logic OUT_DIVIDER_A_SOURCE,
  output logic PLL_C_REFERENCE_SELECT,
  output logic CLOCK_INPUT_ENABLE,
  output logic OTP_WRITE_LOCK,
  output logic [7:0] VARIANT_CODE_FIELD,
  output logic [7:0] CRYSTAL_CAP_TRIM,
  output logic PLL_C_REF_BYPASS_ONE,
  output logic PLL_C_REF_BYPASS_TWO,
  output logic [5:0] PLL_C_REF_DIVIDER,
  output logic [10:0] PLL_C_FEEDBACK_DIVIDER
);

  logic rst_q1;
  logic rst_n;
  logic scl_q;
  logic sda_q;
  ccr_state_t state;
  ccr_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic ack_phase;
  logic next_ack_phase;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [7:0] rd_byte;
  logic [7:0] next_rd_byte;
  logic rw;
  logic next_rw;
  logic mack;
  logic next_mack;
  logic next_oe;
  logic stage_we;
  logic stage_clr;
  logic [7:0] reg_q [CCR_NUM_REGS];
  logic [7:0] stage [CCR_NUM_REGS];
  logic [CCR_NUM_REGS-1:0] stage_vld;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  wire scl_rise = SCL & ~scl_q;
  wire scl_fall = ~SCL & scl_q;
  wire start = scl_q & SCL & sda_q & ~SDA_IN;
  wire stop = scl_q & SCL & ~sda_q & SDA_IN;
  wire busy = (state != ST_IDLE) && (state != ST_HOLD);
  wire byte_done = (bit_cnt == BITS_PER_BYTE);
  wire [1:0] addr_sel = reg_q[0][GC_ADDR_SEL_LSB+1:GC_ADDR_SEL_LSB];
  wire addr_hit = (shift[7:1] == {SLAVE_ADDR_HIGH, addr_sel});
  wire [7:0] ptr_inc = ptr + 8'h01;
  wire ptr_ok = (ptr < 8'(CCR_NUM_REGS));
  wire inc_ok = (ptr_inc < 8'(CCR_NUM_REGS));
  // Reads come only from committed registers
  wire [7:0] rd_cur = ptr_ok ? reg_q[ptr[2:0]] : 8'h00;
  wire [7:0] rd_next = inc_ok ? reg_q[ptr_inc[2:0]] : 8'h00;
  wire rd_bit = rd_byte[~bit_cnt[2:0]];

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_ack_phase = ack_phase;
    next_shift = shift;
    next_ptr = ptr;
    next_rd_byte = rd_byte;
    next_rw = rw;
    next_mack = mack;
    next_oe = SDA_OE;
    stage_we = 1'b0;
    stage_clr = 1'b0;
    if (start) begin
      // A repeated start drops any staged write
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_ack_phase = 1'b0;
      next_oe = 1'b0;
      stage_clr = 1'b1;
    end else if (stop) begin
      // Stop ends any transfer cleanly
      next_state = ST_IDLE;
      next_ack_phase = 1'b0;
      next_oe = 1'b0;
      stage_clr = 1'b1;
    end else if (scl_rise && busy) begin
      if (ack_phase) begin
        next_mack = ~SDA_IN;
      end else if (!byte_done) begin
        next_shift = {shift[6:0], SDA_IN};
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end else if (scl_fall && busy) begin
      if (!ack_phase && byte_done) begin
        // Ninth clock: acknowledge bytes taken, release for reads
        next_ack_phase = 1'b1;
        if (state == ST_RD) begin
          next_oe = 1'b0;
        end else if (state == ST_ADDR && !addr_hit) begin
          next_state = ST_HOLD;
          next_oe = 1'b0;
        end else begin
          next_oe = 1'b1;
        end
        if (state == ST_ADDR) begin
          next_rw = shift[0];
        end
      end else if (!ack_phase && state == ST_RD) begin
        next_oe = ~rd_bit;
      end else if (ack_phase) begin
        next_ack_phase = 1'b0;
        next_bit_cnt = 4'h0;
        next_oe = 1'b0;
        unique case (state)
          ST_ADDR: begin
            if (rw) begin
              next_state = ST_RD;
              next_rd_byte = rd_cur;
              next_oe = ~rd_cur[7];
            end else begin
              next_state = ST_OFFS;
            end
          end
          ST_OFFS: begin
            next_ptr = shift;
            next_state = ST_WR;
          end
          ST_WR: begin
            stage_we = 1'b1;
            next_ptr = ptr_inc;
          end
          ST_RD: begin
            if (mack) begin
              next_ptr = ptr_inc;
              next_rd_byte = rd_next;
              next_oe = ~rd_next[7];
            end else begin
              next_state = ST_HOLD;
            end
          end
          ST_IDLE, ST_HOLD: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      shift <= 8'h00;
      ptr <= 8'h00;
      rd_byte <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      SDA_OE <= 1'b0;
      SDA_OUT <= 1'b0;
    end else begin
      scl_q <= SCL;
      sda_q <= SDA_IN;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      ack_phase <= next_ack_phase;
      shift <= next_shift;
      ptr <= next_ptr;
      rd_byte <= next_rd_byte;
      rw <= next_rw;
      mack <= next_mack;
      SDA_OE <= next_oe;
      SDA_OUT <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CCR_NUM_REGS; gi++) begin : g_reg
      wire hit = stage_we && (ptr == 8'(gi));
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
          reg_q[gi] <= CCR_RESET[gi];
          stage[gi] <= 8'h00;
          stage_vld[gi] <= 1'b0;
        end else begin
          if (stop && stage_vld[gi]) begin
            reg_q[gi] <= stage[gi] & CCR_MASK[gi];
          end
          if (stage_clr) begin
            stage_vld[gi] <= 1'b0;
          end else if (hit) begin
            stage[gi] <= shift;
            stage_vld[gi] <= 1'b1;
          end
        end
      end
      a_stop_commit: assert property (
        @(posedge SYS_CLK) disable iff (!rst_n)
        stop && stage_vld[gi] |=>
          reg_q[gi] == ($past(stage[gi]) & CCR_MASK[gi]))
        else $error("Staged byte not committed at stop");
    end
  endgenerate

  assign OTP_PROGRAMMED = reg_q[0][GC_OTP_PROGRAMMED];
  assign OTP_WRITE_LOCK = reg_q[0][GC_OTP_LOCK];
  assign SLAVE_ADDR_SELECT = addr_sel;
  assign PLL_A_SPREAD_ENABLE = reg_q[0][GC_SPREAD];
  assign OUT_DIVIDER_A_SOURCE = reg_q[0][GC_DIVA_SRC];
  assign PLL_C_REFERENCE_SELECT = reg_q[0][GC_PLLC_REF];
  assign CLOCK_INPUT_ENABLE = reg_q[0][GC_CLKIN_EN];
  assign VARIANT_CODE_FIELD = reg_q[1];
  assign CRYSTAL_CAP_TRIM = reg_q[2];
  assign PLL_C_REF_BYPASS_ONE = reg_q[3][RD_BYPASS_ONE];
  assign PLL_C_REF_BYPASS_TWO = reg_q[3][RD_BYPASS_TWO];
  assign PLL_C_REF_DIVIDER = reg_q[3][RD_DIV_MSB:0];
  assign PLL_C_FEEDBACK_DIVIDER = {reg_q[5][FBH_MSB:0],
    reg_q[4]};

  wire [47:0] cfg_flat = {reg_q[5], reg_q[4], reg_q[3], reg_q[2], reg_q[1],
    reg_q[0]};
  wire [47:0] cfg_reset = {RST_FB_HIGH, RST_FB_LOW, RST_REF_DIV,
    RST_CAP_TRIM, RST_VARIANT, RST_GENERAL};

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_addr_byte_end;
    state == ST_ADDR && scl_fall && byte_done && !ack_phase;
  endsequence
  sequence s_ack_end(ccr_state_t st);
    state == st && scl_fall && ack_phase && !start && !stop;
  endsequence
  sequence s_byte_end(ccr_state_t st);
    state == st && scl_fall && byte_done && !ack_phase && !start && !stop;
  endsequence

  a_addr_miss_quiet: assert property (
    s_addr_byte_end ##0 (!addr_hit && !start && !stop) |=> !SDA_OE ##1
      state == ST_HOLD)
    else $error("Foreign address was acknowledged");
  a_addr_hit_ack: assert property (
    s_addr_byte_end ##0 (addr_hit && !start && !stop) |=> SDA_OE)
    else $error("Own address not acknowledged");
  a_offset_load: assert property (
    s_ack_end(ST_OFFS) |=> ptr == $past(shift) && state == ST_WR)
    else $error("Offset byte not loaded into pointer");
  a_write_ptr_step: assert property (
    s_ack_end(ST_WR) |=> ptr == $past(ptr) + 8'h01)
    else $error("Pointer did not advance after write byte");
  a_read_msb_first: assert property (
    (state == ST_RD && scl_fall && !ack_phase && !byte_done && !start &&
      !stop) |=> SDA_OE == !$past(rd_bit))
    else $error("Read bit out of order");
  a_commit_only_stop: assert property (
    !stop |=> $stable(cfg_flat))
    else $error("Registers changed without a stop");
  a_start_discard: assert property (
    start |=> stage_vld == '0 ##1 $stable(cfg_flat))
    else $error("Staged bytes survived a start");
  a_stop_release: assert property (
    stop |=> state == ST_IDLE && !SDA_OE)
    else $error("Stop did not end the transfer");
  a_reset_defaults: assert property (
    $rose(rst_n) |-> cfg_flat == cfg_reset)
    else $error("Register defaults wrong after reset");
  a_offs_ack: assert property (
    s_byte_end(ST_OFFS) |=> SDA_OE)
    else $error("Offset byte not acknowledged");
  a_data_ack: assert property (
    s_byte_end(ST_WR) |=> SDA_OE)
    else $error("Data byte not acknowledged");
  a_ack_release: assert property (
    s_ack_end(ST_WR) |=> !SDA_OE && state == ST_WR)
    else $error("Data held after write acknowledge");
  a_read_release: assert property (
    s_byte_end(ST_RD) |=> !SDA_OE)
    else $error("Data held over master acknowledge");
  a_read_first: assert property (
    s_ack_end(ST_ADDR) ##0 rw |=> state == ST_RD &&
      rd_byte == $past(rd_cur))
    else $error("Read did not start at pointer");
  a_read_step: assert property (
    s_ack_end(ST_RD) ##0 mack |=> ptr == $past(ptr) + 8'h01 &&
      SDA_OE == !$past(rd_next[7]))
    else $error("Read did not move to next byte");
  a_read_nack: assert property (
    s_ack_end(ST_RD) ##0 !mack |=> state == ST_HOLD && !SDA_OE)
    else $error("Read did not end on master nack");
  a_hold_quiet: assert property (
    (state == ST_HOLD && !start && !stop) |=> state == ST_HOLD && !SDA_OE)
    else $error("Idle slave touched the bus");
  a_fb_high_mask: assert property (
    reg_q[5] == (reg_q[5] & MASK_FB_HIGH))
    else $error("Unused feedback bits were stored");

endmodule

`default_nettype wire

// File: tb/ccr_bus_master.sv
// Purpose: Two-wire bus master model that frames transfers to the slave
// Assumes: SDA has a pull-up; sda_low high pulls the wire down
// Notes: Every SCL phase of a bit spans four system clocks, the high phase of a start eight; SCL idles high
`timescale 1ns/1ps
`default_nettype none
module ccr_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One SCL pulse; data moves only while SCL is low
  task automatic put(input logic b, output logic got);
    tick(2);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(4);
    got = sda;
    scl = 1'b0;
  endtask
  // Also serves as a repeated start from SCL low
  task automatic start();
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put(d[i], g);
    put(1'b1, g);
    ack = !g;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put(1'b1, g);
      d[i] = g;
    end
    put(!more, g);
  endtask
endmodule
`default_nettype wire

// File: tb/test_clock_gen_i2c_config_regs.sv
// Purpose: Self-checking bench for the configuration slave
// Assumes: Master model timing meets the slave's sampling needs
// Notes: Expected register image tracks every committed write
`timescale 1ns/1ps
`default_nettype none
module test_clock_gen_i2c_config_regs;
  import ccr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  wire scl, sda_low, sda_out, sda_oe, otp, spr, dsrc, cref, cin, lock;
  wire byp1, byp2;
  wire [1:0] sel;
  wire [7:0] vcode, trim;
  wire [5:0] rdiv;
  wire [10:0] fb;
  wire [7:0] gen_port = {otp, sel, spr, dsrc, cref, cin, lock};
  wire sda = !sda_low & (sda_oe ? sda_out : 1'b1);
  logic [7:0] exp [6] = '{RST_GENERAL, RST_VARIANT, RST_CAP_TRIM,
    RST_REF_DIV, RST_FB_LOW, RST_FB_HIGH};
  logic [7:0] buf_q [$];
  logic [7:0] d, offs;
  logic ack;
  int error_cnt = 0;
  int tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  ccr_bus_master m (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ccr_slave DUT (.SYS_CLK(sys_clk), .RST_B(rst_b), .SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .OTP_PROGRAMMED(otp), .SLAVE_ADDR_SELECT(sel),
    .PLL_A_SPREAD_ENABLE(spr), .OUT_DIVIDER_A_SOURCE(dsrc),
    .PLL_C_REFERENCE_SELECT(cref), .CLOCK_INPUT_ENABLE(cin),
    .OTP_WRITE_LOCK(lock), .VARIANT_CODE_FIELD(vcode),
    .CRYSTAL_CAP_TRIM(trim), .PLL_C_REF_BYPASS_ONE(byp1),
    .PLL_C_REF_BYPASS_TWO(byp2), .PLL_C_REF_DIVIDER(rdiv),
    .PLL_C_FEEDBACK_DIVIDER(fb));
  function automatic logic [7:0] dev(input logic [1:0] s);
    return 8'hD0 + {5'h0, s, 1'b0};
  endfunction
  task automatic chk_byte(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic chk_ports();
    chk_byte("general", exp[0], gen_port);
    chk_byte("variant", exp[1], vcode);
    chk_byte("trim", exp[2], trim);
    chk_byte("refdiv", exp[3], {byp1, byp2, rdiv});
    chk_byte("fb low", exp[4], fb[7:0]);
    chk_byte("fb high", exp[5], {5'h00, fb[10:8]});
  endtask
  task automatic frame_w(input logic [7:0] o);
    m.start();
    m.send(dev(exp[0][6:5]), ack);
    chk_bit("addr ack", 1'b1, ack);
    m.send(o, ack);
    chk_bit("offset ack", 1'b1, ack);
    foreach (buf_q[i]) begin
      m.send(buf_q[i], ack);
      chk_bit("data ack", 1'b1, ack);
    end
  endtask
  task automatic commit(input logic [7:0] o);
    foreach (buf_q[i])
      if (o + i < CCR_NUM_REGS) exp[o + i] = buf_q[i] & CCR_MASK[o + i];
  endtask
  task automatic rd(input logic [7:0] o, input int n);
    buf_q = {};
    frame_w(o);
    m.start();
    m.send(dev(exp[0][6:5]) | 8'h01, ack);
    chk_bit("read addr ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      m.recv(i < n - 1, d);
      chk_byte("read", (o + i < 6) ? exp[o + i] : 8'h00, d);
    end
    m.stop();
  endtask
  task automatic wr(input logic [7:0] o);
    frame_w(o);
    chk_ports();
    m.stop();
    commit(o);
    chk_ports();
  endtask
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h0f7c));
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    m.tick(4);
    chk_ports();
    rd(8'h00, 6);
    $display("test reset done");
    for (int t = 0; t < 5; t++) begin
      buf_q = {};
      offs = 8'($urandom_range(0, 5));
      repeat ($urandom_range(1, 4)) buf_q.push_back(8'($urandom));
      wr(offs);
      rd(offs, buf_q.size());
    end
    $display("test random done");
    buf_q = '{8'hFF, 8'hFF, 8'hFF, 8'hAA};
    wr(8'h03);
    rd(8'h04, 3);
    $display("test block write done");
    buf_q = '{8'($urandom), 8'($urandom)};
    frame_w(8'h01);
    rd(8'h01, 2);
    chk_ports();
    $display("test abort done");
    for (int s = 0; s < 4; s++) begin
      buf_q = '{{exp[0][7], s[1:0], exp[0][4:0]}};
      wr(8'h00);
      for (int a = 0; a < 4; a++) begin
        m.start();
        m.send(dev(a[1:0]), ack);
        chk_bit("select ack", a == s, ack);
        m.stop();
      end
    end
    $display("test address done");
    stop_test();
  end
endmodule
`default_nettype wire
